// [logic/tcs_core.sv]
// Trip circuit supervision block with APB register slave.
// Assumes opto inputs and breaker status arrive asynchronously, and
// trip output drives come from logic on clk_sys.
//
// Contract
// - Fail when watch input stays dead longer than the supervision delay.
// - Suspend timing and failure while either trip output is energized.
// - Delay settable 0.100 s to 10.00 s, default 0.500 s.
// - Supervision is off after reset until enabled.
// - Two binary inputs may both feed the one watch input.
// - General mode always; closed-breaker-only mode only when breaker closed.
// - Failure drives failure output, breaker alarm and both indicators.
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "tcs_regs.svh"
module tcs_core
   import tcs_pkg::*;
#(
   parameter int unsigned DELAY_MS_W = 14,
   // Clock cycles in one millisecond of supervision time
   parameter int unsigned CYC_PER_MS = `TCS_CYC_PER_MS
)(
   // Clock and reset
   input  wire logic   clk_sys,
   input  wire logic   reset_n,
   // APB slave
   input  apb_req_s    apb_req,
   output apb_rsp_s    apb_rsp,
   // Trip circuit pins
   input  wire logic   watch_pin_a,
   input  wire logic   watch_pin_b,
   input  wire logic   breaker_closed_pin,
   // Trip drives from the relay's own logic
   input  wire logic   protection_trip,
   input  wire logic   breaker_trip_command,
   // Alarm outputs and indicators
   output logic        trip_circuit_failure_output,
   output logic        breaker_alarm_output,
   output logic        supervision_led,
   output logic        breaker_alarm_led,
   output logic        irq
);

   typedef struct packed {
      sup_state_e              state;
      logic [31:0]             ctrl;
      logic [DELAY_MS_W-1:0]   delay_ms;
      logic [17:0]             sub_cnt;
      logic [DELAY_MS_W-1:0]   ms_cnt;
      logic [1:0]              irq_stat;
      logic [1:0]              irq_mask;
      apb_rsp_s                rsp;
      logic [4:0]              outs;
   } core_s;

   core_s st_q;
   core_s st_d;

   logic pin_a;
   logic pin_b;
   logic brk_closed;

   // Clamp a written delay into the legal range
   function automatic logic [DELAY_MS_W-1:0] clamp_ms(
      input logic [31:0] v);
      logic [31:0] r;
      r = v;
      if (v < `TCS_DELAY_MIN_MS) r = `TCS_DELAY_MIN_MS;
      if (v > `TCS_DELAY_MAX_MS) r = `TCS_DELAY_MAX_MS;
      return r[DELAY_MS_W-1:0];
   endfunction

   // ================================================================
   // Pin synchronisers
   tcs_pin_sync u_sync_a (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .pin_raw   (watch_pin_a),
      .pin_level (pin_a)
   );
   tcs_pin_sync u_sync_b (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .pin_raw   (watch_pin_b),
      .pin_level (pin_b)
   );
   tcs_pin_sync u_sync_c (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .pin_raw   (breaker_closed_pin),
      .pin_level (brk_closed)
   );

   // ================================================================
   // Supervision and register logic
   logic        voltage;
   logic        suspend;
   logic        active;
   logic        ms_tick;
   logic        fail_now;
   logic        ok_now;
   logic        acc;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic [17:0] cyc_per_ms;

   always_comb begin
      st_d       = st_q;
      cyc_per_ms = 18'(CYC_PER_MS - 1);
      // Either assigned input counts as the watch input voltage
      voltage = (st_q.ctrl[`TCS_CTRL_IN0_BIT] & pin_a)
              | (st_q.ctrl[`TCS_CTRL_IN1_BIT] & pin_b);
      suspend = protection_trip | breaker_trip_command;
      active  = st_q.ctrl[`TCS_CTRL_EN_BIT]
              & (~st_q.ctrl[`TCS_CTRL_CLOSED_BIT] | brk_closed);
      ms_tick  = (st_q.sub_cnt == cyc_per_ms);
      fail_now = 1'b0;
      ok_now   = 1'b0;
      acc = apb_req.psel & apb_req.penable;
      wr  = acc & apb_req.pwrite;
      rd  = acc & ~apb_req.pwrite;

      unique case (st_q.state)
         ST_OFF: begin
            st_d.sub_cnt = '0;
            st_d.ms_cnt  = '0;
            if (active) begin
               st_d.state = ST_WATCH;
            end
         end
         ST_WATCH: begin
            if (!active) begin
               st_d.state = ST_OFF;
            end else if (suspend || voltage) begin
               // Timer restarts so a trip pulse never counts as dead time
               st_d.sub_cnt = '0;
               st_d.ms_cnt  = '0;
            end else if (ms_tick) begin
               st_d.sub_cnt = '0;
               if (st_q.ms_cnt >= st_q.delay_ms) begin
                  st_d.state = ST_FAIL;
                  fail_now   = 1'b1;
               end else begin
                  st_d.ms_cnt = st_q.ms_cnt + 1'b1;
               end
            end else begin
               st_d.sub_cnt = st_q.sub_cnt + 1'b1;
            end
         end
         ST_FAIL: begin
            st_d.sub_cnt = '0;
            st_d.ms_cnt  = '0;
            if (!active) begin
               st_d.state = ST_OFF;
            end else if (voltage) begin
               st_d.state = ST_WATCH;
               ok_now     = 1'b1;
            end
         end
         default: begin
            st_d.state = ST_OFF;
         end
      endcase

      // Register reads; interrupt status read clears sticky bits
      unique case (apb_req.paddr)
         `TCS_CTRL_ADDR:     rdata = st_q.ctrl;
         `TCS_DELAY_ADDR:    rdata = 32'(st_q.delay_ms);
         `TCS_STATUS_ADDR:   rdata = {29'h0, voltage, suspend,
                                      st_q.state == ST_FAIL};
         `TCS_IRQ_STAT_ADDR: rdata = {30'h0, st_q.irq_stat};
         `TCS_IRQ_MASK_ADDR: rdata = {30'h0, st_q.irq_mask};
         default:            rdata = 32'h0;
      endcase

      // Clear only the bits the read returned, so an event that lands
      // between setup and access is not lost
      if (rd && apb_req.paddr == `TCS_IRQ_STAT_ADDR) begin
         st_d.irq_stat = st_q.irq_stat & ~st_q.rsp.prdata[1:0];
      end
      // Set wins over the clearing read
      if (fail_now) st_d.irq_stat[`TCS_IRQ_FAIL_BIT] = 1'b1;
      if (ok_now)   st_d.irq_stat[`TCS_IRQ_OK_BIT]   = 1'b1;

      if (wr) begin
         unique case (apb_req.paddr)
            `TCS_CTRL_ADDR:     st_d.ctrl = {28'h0, apb_req.pwdata[3:0]};
            `TCS_DELAY_ADDR:    st_d.delay_ms = clamp_ms(apb_req.pwdata);
            `TCS_IRQ_MASK_ADDR: st_d.irq_mask = apb_req.pwdata[1:0];
            default:            ;
         endcase
      end

      // Access answered in one cycle after setup
      st_d.rsp.pready  = apb_req.psel & ~st_q.rsp.pready;
      st_d.rsp.prdata  = rdata;
      st_d.rsp.pslverr = 1'b0;
      if (!(apb_req.psel && !st_q.rsp.pready)) begin
         st_d.rsp.prdata = 32'h0;
      end

      // Failure drives both alarms and both indicators
      st_d.outs[0] = (st_d.state == ST_FAIL);
      st_d.outs[1] = (st_d.state == ST_FAIL);
      st_d.outs[2] = (st_d.state == ST_FAIL);
      st_d.outs[3] = (st_d.state == ST_FAIL);
      st_d.outs[4] = |(st_d.irq_stat & st_d.irq_mask);
   end

   // ================================================================
   // State register; supervision starts switched off
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_q          <= '0;
         st_q.state    <= ST_OFF;
         st_q.ctrl     <= `TCS_CTRL_RESET;
         st_q.delay_ms <= DELAY_MS_W'(`TCS_DELAY_DEF_MS);
      end else begin
         st_q <= st_d;
      end
   end

   assign apb_rsp                     = st_q.rsp;
   assign trip_circuit_failure_output = st_q.outs[0];
   assign breaker_alarm_output        = st_q.outs[1];
   assign supervision_led             = st_q.outs[2];
   assign breaker_alarm_led           = st_q.outs[3];
   assign irq                         = st_q.outs[4];

endmodule

// [logic/tcs_regs.svh]
// Register offsets, field positions, reset values and timing counts
// for the trip circuit supervision block.
// Assumes the includer works on a 250 MHz system clock.
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH

// ====================================================================
// Register byte addresses
`define TCS_CTRL_ADDR     12'h000
`define TCS_DELAY_ADDR    12'h004
`define TCS_STATUS_ADDR   12'h008
`define TCS_IRQ_STAT_ADDR 12'h00c
`define TCS_IRQ_MASK_ADDR 12'h010

// ====================================================================
// Control fields
`define TCS_CTRL_EN_BIT     0
`define TCS_CTRL_CLOSED_BIT 1
`define TCS_CTRL_IN0_BIT    2
`define TCS_CTRL_IN1_BIT    3
`define TCS_CTRL_RESET      32'h0000_0004

// ====================================================================
// Delay in milliseconds: 100 ms to 10000 ms, default 500 ms
`define TCS_DELAY_MIN_MS  32'd100
`define TCS_DELAY_MAX_MS  32'd10000
`define TCS_DELAY_DEF_MS  32'd500
`define TCS_CLK_MHZ       32'd250
`define TCS_CYC_PER_MS    (`TCS_CLK_MHZ * 32'd1000)

// ====================================================================
// Status and interrupt fields
`define TCS_ST_FAIL_BIT  0
`define TCS_ST_SUSP_BIT  1
`define TCS_ST_VOLT_BIT  2
`define TCS_IRQ_FAIL_BIT 0
`define TCS_IRQ_OK_BIT   1

`endif

// [logic/tcs_pkg.sv]
// Types shared by the trip circuit supervision design.
// Assumes tcs_regs.svh supplies all numbers.
package tcs_pkg;

   // ================================================================
   // APB request and answer
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_s;

   // Supervision states
   typedef enum logic [2:0] {
      ST_OFF   = 3'b001,
      ST_WATCH = 3'b010,
      ST_FAIL  = 3'b100
   } sup_state_e;

   // Three-stage pin sampler state
   typedef struct packed {
      logic [2:0] sync;
      logic       level;
   } pin_sync_s;

endpackage

// [logic/tcs_pin_sync.sv]
// Three flip-flop synchroniser with agreement filter for opto inputs.
// Assumes pin_raw is asynchronous to clk_sys.
`timescale 1ns/100ps
module tcs_pin_sync
   import tcs_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic reset_n,
   // Pin and filtered level
   input  wire logic pin_raw,
   output logic      pin_level
);

   pin_sync_s st_q;
   pin_sync_s st_d;

   // ================================================================
   // Level changes only once stages two and three agree
   always_comb begin
      st_d      = st_q;
      st_d.sync = {st_q.sync[1:0], pin_raw};
      if (st_q.sync[1] == st_q.sync[2]) begin
         st_d.level = st_q.sync[2];
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pin_level = st_q.level;

endmodule

// [testbench/tcs_core_sva.sv]
// Port checker for the trip circuit supervision block.
// Assumes it is bound into tcs_core and sees only its ports.
`timescale 1ns/100ps
module tcs_core_sva
   import tcs_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Ports watched
   input apb_req_s  apb_req,
   input apb_rsp_s  apb_rsp,
   input wire logic watch_pin_a,
   input wire logic watch_pin_b,
   input wire logic protection_trip,
   input wire logic breaker_trip_command,
   input logic      trip_circuit_failure_output,
   input logic      breaker_alarm_output,
   input logic      supervision_led,
   input logic      breaker_alarm_led
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // ===========================================================
   // Both pins high means voltage whenever at least one input is assigned
   logic f;
   logic live;
   assign f    = trip_circuit_failure_output;
   assign live = watch_pin_a && watch_pin_b;
   a_ready_after_setup: assert property (apb_req.psel && !apb_req.penable
      |=> apb_rsp.pready) else $error("no ready after setup");
   a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("ready held too long");
   a_no_error: assert property (!apb_rsp.pslverr) else $error("slave error");
   a_alarm_pair: assert property (f == breaker_alarm_output)
      else $error("alarm differs from failure");
   a_led_pair: assert property (f |-> supervision_led && breaker_alarm_led)
      else $error("indicator missing");
   a_fail_not_tripping: assert property ($rose(f) |->
      $past(!protection_trip && !breaker_trip_command))
      else $error("failure while suspended");
   a_fail_needs_dead: assert property ($rose(f) |-> $past(!live, 6))
      else $error("failure with voltage");
   a_fail_clears: assert property (live[*8] |-> !f)
      else $error("failure kept with voltage");
   c_write: cover property (apb_req.psel && apb_req.penable && apb_req.pwrite);
   c_trip: cover property (protection_trip);
   c_fail: cover property ($rose(f));
   c_recover: cover property ($fell(f));
endmodule

bind tcs_core tcs_core_sva i_tcs_core_sva (.clk_sys, .reset_n, .apb_req,
   .apb_rsp, .watch_pin_a, .watch_pin_b, .protection_trip,
   .breaker_trip_command, .trip_circuit_failure_output,
   .breaker_alarm_output, .supervision_led, .breaker_alarm_led);

// [testbench/tcs_trip_circuit.sv]
// Model of the external trip circuit seen through the opto inputs.
// Assumes the bench sets circuit health and breaker position.
`timescale 1ns/100ps
module tcs_trip_circuit (
   // Clock
   input  wire logic clk_sys,
   // Circuit condition
   input  wire logic live_a,
   input  wire logic live_b,
   input  wire logic closed,
   // Pins into the relay
   output logic      watch_pin_a,
   output logic      watch_pin_b,
   output logic      breaker_closed_pin
);
   // Contacts move on the edge; a dead opto reads low
   always_ff @(posedge clk_sys) begin
      watch_pin_a        <= live_a;
      watch_pin_b        <= live_b;
      breaker_closed_pin <= closed;
   end
endmodule

// [testbench/trip_circuit_supervision_bench.sv]
// Self-checking bench for the trip circuit supervision block.
// Assumes the package and register header are compiled first.
`timescale 1ns/100ps
`include "tcs_regs.svh"
module trip_circuit_supervision_bench
   import tcs_pkg::*;
;
   logic        clk_sys = 0, reset_n = 0, trip = 0, cmd = 0;
   logic        live_a = 1, live_b = 1, closed = 1;
   logic        pin_a, pin_b, pin_c, fail, alarm, irq, led_s, led_b;
   apb_req_s    req = '0;
   apb_rsp_s    rsp;
   logic [31:0] q[$];
   logic [4:0]  qo[$];
   logic [4:0]  o_last = '0, o_exp;
   logic [31:0] r;
   int          errors = 0, n_checks = 0, cyc = 0;
   tcs_trip_circuit i_tcs_trip_circuit (.clk_sys, .live_a, .live_b,
      .closed, .watch_pin_a(pin_a), .watch_pin_b(pin_b),
      .breaker_closed_pin(pin_c));
   // One millisecond shortened to 20 cycles so failures fit the run
   tcs_core #(.CYC_PER_MS(20)) i_tcs_core (.clk_sys, .reset_n,
      .apb_req(req), .apb_rsp(rsp),
      .watch_pin_a(pin_a), .watch_pin_b(pin_b), .breaker_closed_pin(pin_c),
      .protection_trip(trip), .breaker_trip_command(cmd),
      .trip_circuit_failure_output(fail), .breaker_alarm_output(alarm),
      .supervision_led(led_s), .breaker_alarm_led(led_b), .irq);
   // ===========================================================
   // Clock, and a ceiling well above the few thousand cycles used
   initial forever #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         close_out;
      end
   end
   task chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // One APB transfer; held until ready is seen at an edge
   task xfer(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge clk_sys);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk_sys);
      req.penable <= 1'b1;
      do @(posedge clk_sys); while (rsp.pready !== 1'b1);
      req <= '0;
   endtask
   task rd(logic [11:0] a, logic [31:0] exp);
      q.push_back(exp);
      xfer(1'b0, a, 32'h0);
   endtask
   // Input A dead: quiet before 100 ms of 20 cycles, failed after it
   task fail_run;
      qo.push_back(5'h1f);
      live_a <= 0;
      repeat (1950) @(posedge clk_sys);
      rd(`TCS_STATUS_ADDR, 32'h0);
      repeat (150) @(posedge clk_sys);
      rd(`TCS_STATUS_ADDR, 32'h1);
   endtask
   task close_out;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Read data is compared at the edge it is taken
   always @(posedge clk_sys)
      if (req.psel && req.penable && rsp.pready && !req.pwrite)
         chk("prdata", rsp.prdata, q.pop_front());
   // Output changes are matched in order against the noted levels
   always @(posedge clk_sys)
      if (reset_n && {irq, led_b, led_s, alarm, fail} !== o_last) begin
         o_exp  = (qo.size() > 0) ? qo.pop_front() : o_last;
         chk("outputs", {irq, led_b, led_s, alarm, fail}, o_exp);
         o_last = {irq, led_b, led_s, alarm, fail};
      end
   initial begin
      void'($urandom(46));
      repeat (4) @(posedge clk_sys);
      reset_n <= 1;
      rd(`TCS_CTRL_ADDR, `TCS_CTRL_RESET);
      rd(`TCS_DELAY_ADDR, `TCS_DELAY_DEF_MS);
      rd(`TCS_IRQ_MASK_ADDR, 32'h0);
      rd(12'h014, 32'h0);
      $display("test reset done");
      xfer(1, `TCS_DELAY_ADDR, 32'd50);
      rd(`TCS_DELAY_ADDR, `TCS_DELAY_MIN_MS);
      xfer(1, `TCS_DELAY_ADDR, 32'd20000);
      rd(`TCS_DELAY_ADDR, `TCS_DELAY_MAX_MS);
      r = 32'd100 + $urandom % 9901;
      xfer(1, `TCS_DELAY_ADDR, r);
      rd(`TCS_DELAY_ADDR, r);
      $display("test delay done");
      // Dead input A far shorter than any delay: no failure yet
      xfer(1, `TCS_CTRL_ADDR, 32'h5);
      live_a <= 0;
      repeat (1000) @(posedge clk_sys);
      rd(`TCS_STATUS_ADDR, 32'h0);
      trip <= 1;
      repeat (10) @(posedge clk_sys);
      rd(`TCS_STATUS_ADDR, 32'h2);
      trip <= 0;
      cmd <= 1;
      repeat (10) @(posedge clk_sys);
      rd(`TCS_STATUS_ADDR, 32'h2);
      cmd <= 0;
      $display("test suspend done");
      xfer(1, `TCS_CTRL_ADDR, 32'h9);
      repeat (10) @(posedge clk_sys);
      rd(`TCS_STATUS_ADDR, 32'h4);
      xfer(1, `TCS_CTRL_ADDR, 32'h7);
      live_a <= 1;
      repeat (10) @(posedge clk_sys);
      rd(`TCS_STATUS_ADDR, 32'h4);
      xfer(1, `TCS_IRQ_MASK_ADDR, 32'h3);
      rd(`TCS_IRQ_MASK_ADDR, 32'h3);
      $display("test inputs done");
      xfer(1, `TCS_DELAY_ADDR, `TCS_DELAY_MIN_MS);
      fail_run;
      qo.push_back(5'h0f);
      rd(`TCS_IRQ_STAT_ADDR, 32'h1);
      qo.push_back(5'h10);
      live_a <= 1;
      repeat (10) @(posedge clk_sys);
      rd(`TCS_STATUS_ADDR, 32'h4);
      qo.push_back(5'h00);
      rd(`TCS_IRQ_STAT_ADDR, 32'h2);
      $display("test failure done");
      // Breaker open: closed-only mode must not time, general mode must
      closed <= 0;
      live_a <= 0;
      repeat (2200) @(posedge clk_sys);
      rd(`TCS_STATUS_ADDR, 32'h0);
      xfer(1, `TCS_CTRL_ADDR, 32'h5);
      fail_run;
      $display("test position done");
      chk("notes left", qo.size(), 32'h0);
      close_out;
   end
endmodule
